// file: include/ipm_defs.svh
// constants for the inactivity power manager
`ifndef IPM_DEFS_SVH
`define IPM_DEFS_SVH
`define IPM_CLK_HZ          25000000
`define IPM_SEC_CYC         (`IPM_CLK_HZ)
`define IPM_MIN_SEC         60
`define IPM_BTN_HOLD_SEC    4
`define IPM_MIN_PERIOD_MIN  6'h01
`define IPM_MAX_PERIOD_MIN  6'h3c
`define IPM_HDD_MAX_MIN     4'hf
`define IPM_DUTY_DEFAULT    3'h5
`define IPM_DUTY_STEPS      4'h8
`define IPM_IRQ_WAKE_MASK   16'hfef8
`endif

// file: include/ipm_pkg.sv
// types shared by the inactivity power manager
package ipm_pkg;
    typedef enum logic [1:0] {IPM_PROF_USER, IPM_PROF_MIN, IPM_PROF_MAX} ipm_prof_e;
    typedef enum logic [1:0] {IPM_VID_SYNC_BLANK, IPM_VID_BLANK, IPM_VID_DPMS} ipm_vid_e;
    typedef enum logic [1:0] {IPM_PON_LAST, IPM_PON_ON, IPM_PON_OFF} ipm_pon_e;
    typedef enum logic [1:0] {IPM_ST_FULL, IPM_ST_THROTTLE, IPM_ST_VIDOFF,
                              IPM_ST_SUSPEND} ipm_state_e;
endpackage

// file: include/ipm_tick_if.sv
// tick bundle passed from the timebase to the sequencer
`timescale 1ns/10ps
interface ipm_tick_if;
    logic sec_tick;
    logic min_tick;
    logic duty_tick;
    modport src (output sec_tick, output min_tick, output duty_tick);
    modport dst (input sec_tick, input min_tick, input duty_tick);
endinterface

// file: src/ipm_timebase.sv
// second, minute and duty-slot tick dividers
`timescale 1ns/10ps
`include "ipm_defs.svh"
module ipm_timebase
    import ipm_pkg::*;
#(
    parameter int SEC_CYC = `IPM_SEC_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    ipm_tick_if.src   tick
);
    localparam int DUTY_CYC = SEC_CYC / 8;
    logic [31:0] sec_cnt_ff;
    logic [31:0] duty_cnt_ff;
    logic [5:0]  min_cnt_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sec_cnt_ff <= 32'h0;
        else if (sec_cnt_ff == 32'(SEC_CYC - 1))
            sec_cnt_ff <= 32'h0;
        else
            sec_cnt_ff <= sec_cnt_ff + 32'h1;
    end

    // duty slot is one eighth of a second so a duty step is 12.5 percent
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            duty_cnt_ff <= 32'h0;
        else if (duty_cnt_ff >= 32'(DUTY_CYC - 1))
            duty_cnt_ff <= 32'h0;
        else
            duty_cnt_ff <= duty_cnt_ff + 32'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            min_cnt_ff <= 6'h0;
        else if (tick.sec_tick)
            min_cnt_ff <= (min_cnt_ff == 6'(`IPM_MIN_SEC - 1)) ? 6'h0 : min_cnt_ff + 6'h1;
    end

    assign tick.sec_tick  = (sec_cnt_ff == 32'(SEC_CYC - 1));
    assign tick.duty_tick = (duty_cnt_ff >= 32'(DUTY_CYC - 1));
    assign tick.min_tick  = tick.sec_tick && (min_cnt_ff == 6'(`IPM_MIN_SEC - 1));
endmodule

// file: src/ipm_sync.sv
// three-stage synchroniser bank with agreement detect
`timescale 1ns/10ps
module ipm_sync
#(
    parameter int W = 8
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    s1_ff[i]  <= 1'b0;
                    s2_ff[i]  <= 1'b0;
                    s3_ff[i]  <= 1'b0;
                    out_ff[i] <= 1'b0;
                end
                else
                begin
                    s1_ff[i] <= async_in[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    // a change counts only once stages two and three agree
                    if (s2_ff[i] == s3_ff[i])
                        out_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate

    assign sync_out = out_ff;
endmodule

// file: src/ipm_power_mgr.sv
// inactivity driven power state sequencer
`timescale 1ns/10ps
`include "ipm_defs.svh"
module ipm_power_mgr
    import ipm_pkg::*;
#(
    parameter int SEC_CYC = `IPM_SEC_CYC
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // configuration
    input  wire logic       acpi_en,
    input  wire logic       os_apm_ctrl,
    input  wire ipm_prof_e  profile,
    input  wire logic [5:0] throttle_min,
    input  wire logic [5:0] vidoff_min,
    input  wire logic [5:0] suspend_min,
    input  wire logic [3:0] hdd_min,
    input  wire logic       hdd_off_on_suspend,
    input  wire logic [2:0] duty_sel,
    input  wire logic       video_mon_en,
    input  wire ipm_vid_e   video_method,
    input  wire logic       button_delay_mode,
    input  wire ipm_pon_e   power_on_after_loss,
    input  wire logic       ring_wake_en,
    input  wire logic       rtc_wake_en,
    input  wire logic       alarm_resume_en,
    input  wire logic       lan_wake_en,
    input  wire logic [15:0] irq_reload_en,
    input  wire logic       nmi_reload_en,
    input  wire logic [3:0] ide_reload_en,
    input  wire logic       fdd_reload_en,
    input  wire logic       ser_reload_en,
    input  wire logic       par_reload_en,
    // os requests, same clock domain
    input  wire logic       os_req_valid,
    input  wire ipm_state_e os_req_state,
    // activity and wake pins
    input  wire logic [15:0] irq_act,
    input  wire logic       nmi_act,
    input  wire logic [3:0] ide_act,
    input  wire logic       fdd_act,
    input  wire logic       ser_act,
    input  wire logic       par_act,
    input  wire logic       video_act,
    input  wire logic       ring_ind,
    input  wire logic       rtc_alarm,
    input  wire logic       alarm_match,
    input  wire logic       lan_magic,
    input  wire logic       power_button,
    // mains restore
    input  wire logic       mains_restore,
    input  wire logic       last_state_on,
    // outputs
    output ipm_state_e      pm_state,
    output logic            cpu_clk_en,
    output logic            video_on,
    output logic            sync_on,
    output logic            blank_write,
    output logic            disk_on,
    output logic            supply_on
);
    // ************************************************************
    // input synchronisation
    // ************************************************************
    localparam int NS = 16 + 1 + 4 + 5 + 5;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] syn;
    logic [NS-1:0] syn_d_ff;
    ipm_tick_if    tick ();

    assign raw_in = {irq_act, nmi_act, ide_act, fdd_act, ser_act, par_act,
                     video_act, ring_ind, rtc_alarm, alarm_match, lan_magic,
                     power_button, 1'b0};

    ipm_sync #(.W(NS)) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (raw_in),
        .sync_out (syn)
    );

    ipm_timebase #(.SEC_CYC(SEC_CYC)) u_tb (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            syn_d_ff <= '0;
        else
            syn_d_ff <= syn;
    end

    logic [NS-1:0] rise;
    assign rise = syn & ~syn_d_ff;

    logic [15:0] s_irq;
    logic        s_nmi, s_fdd, s_ser, s_par, s_vid, s_ring, s_rtc, s_alm, s_lan, s_btn;
    logic [3:0]  s_ide;
    assign s_irq  = rise[NS-1 -: 16];
    assign s_nmi  = rise[14];
    assign s_ide  = rise[13:10];
    assign s_fdd  = rise[9];
    assign s_ser  = rise[8];
    assign s_par  = rise[7];
    assign s_vid  = syn[6];
    assign s_ring = rise[5];
    assign s_rtc  = rise[4];
    assign s_alm  = rise[3];
    assign s_lan  = rise[2];
    assign s_btn  = syn[1];

    // ************************************************************
    // wake and reload decode
    // ************************************************************
    logic hw_ctrl;
    logic reload;
    logic wake;
    logic disk_act;
    ipm_state_e state_ff;

    // acpi stops the hardware sequencer and holds the full state; apm control lets the os drive
    assign hw_ctrl = !acpi_en;

    assign reload = (|(s_irq & irq_reload_en & 16'(`IPM_IRQ_WAKE_MASK)))
                  | (s_nmi & nmi_reload_en)
                  | (|(s_ide & ide_reload_en))
                  | (s_fdd & fdd_reload_en)
                  | (s_ser & ser_reload_en)
                  | (s_par & par_reload_en);

    assign wake = reload
                | (s_rtc & rtc_wake_en)
                | (s_ring & ring_wake_en && state_ff == IPM_ST_SUSPEND)
                | (s_alm & alarm_resume_en & rtc_wake_en
                   && state_ff == IPM_ST_SUSPEND);

    assign disk_act = |s_ide;

    // ************************************************************
    // timeout selection
    // ************************************************************
    function automatic logic [5:0] pick_min(input ipm_prof_e p, input logic [5:0] user);
        unique case (p)
            IPM_PROF_MAX:  pick_min = `IPM_MIN_PERIOD_MIN;
            IPM_PROF_MIN:  pick_min = `IPM_MAX_PERIOD_MIN;
            IPM_PROF_USER: pick_min = user;
            default:       pick_min = user;
        endcase
    endfunction

    logic [5:0] lim_thr, lim_vid, lim_sus, lim_cur;
    assign lim_thr = pick_min(profile, throttle_min);
    assign lim_vid = pick_min(profile, vidoff_min);
    assign lim_sus = pick_min(profile, suspend_min);

    always_comb
    begin
        unique case (state_ff)
            IPM_ST_FULL:     lim_cur = lim_thr;
            IPM_ST_THROTTLE: lim_cur = lim_vid;
            IPM_ST_VIDOFF:   lim_cur = lim_sus;
            IPM_ST_SUSPEND:  lim_cur = 6'h0;
        endcase
    end

    // ************************************************************
    // system idle timer
    // ************************************************************
    logic [5:0] idle_min_ff;
    logic       idle_restart;
    logic       idle_expire;

    assign idle_restart = wake
                        | (video_mon_en & s_vid && state_ff == IPM_ST_THROTTLE);
    // zero timeout means the stage is disabled
    assign idle_expire = (lim_cur != 6'h0) && (idle_min_ff >= lim_cur);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            idle_min_ff <= 6'h0;
        else if (idle_restart || idle_expire || !hw_ctrl)
            idle_min_ff <= 6'h0;
        else if (tick.min_tick && idle_min_ff != 6'h3f)
            idle_min_ff <= idle_min_ff + 6'h1;
    end

    // ************************************************************
    // power state machine
    // ************************************************************
    ipm_state_e nxt_state;
    logic       btn_suspend;

    always_comb
    begin
        nxt_state = state_ff;
        if (!hw_ctrl)
            nxt_state = IPM_ST_FULL;
        // without apm control the os calls are simply dropped
        else if (os_apm_ctrl && os_req_valid)
            nxt_state = os_req_state;
        else if (wake)
            nxt_state = IPM_ST_FULL;
        else if (idle_expire && !os_apm_ctrl)
        begin
            unique case (state_ff)
                IPM_ST_FULL:     nxt_state = IPM_ST_THROTTLE;
                IPM_ST_THROTTLE: nxt_state = IPM_ST_VIDOFF;
                IPM_ST_VIDOFF:   nxt_state = IPM_ST_SUSPEND;
                IPM_ST_SUSPEND:  nxt_state = IPM_ST_SUSPEND;
            endcase
        end
        // a held button wins over any other request in that cycle
        if (hw_ctrl && btn_suspend)
            nxt_state = IPM_ST_SUSPEND;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_ff <= IPM_ST_FULL;
        else
            state_ff <= nxt_state;
    end

    // ************************************************************
    // power button and supply
    // ************************************************************
    logic [2:0] btn_sec_ff;
    logic       btn_done_ff;
    logic       supply_ff;
    logic       restore_done_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            btn_sec_ff <= 3'h0;
        else if (!s_btn)
            btn_sec_ff <= 3'h0;
        else if (tick.sec_tick && btn_sec_ff != 3'(`IPM_BTN_HOLD_SEC))
            btn_sec_ff <= btn_sec_ff + 3'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            btn_done_ff <= 1'b0;
        else if (!s_btn)
            btn_done_ff <= 1'b0;
        else if (btn_suspend)
            btn_done_ff <= 1'b1;
    end

    // a held button suspends once per press, not every cycle
    assign btn_suspend = button_delay_mode && s_btn && !btn_done_ff
                       && btn_sec_ff == 3'(`IPM_BTN_HOLD_SEC);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            restore_done_ff <= 1'b0;
        else if (mains_restore)
            restore_done_ff <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            supply_ff <= 1'b0;
        else if (mains_restore && !restore_done_ff)
        begin
            unique case (power_on_after_loss)
                IPM_PON_ON:   supply_ff <= 1'b1;
                IPM_PON_OFF:  supply_ff <= 1'b0;
                IPM_PON_LAST: supply_ff <= last_state_on;
                default:      supply_ff <= last_state_on;
            endcase
        end
        else if (!supply_ff && s_lan && lan_wake_en)
            supply_ff <= 1'b1;
        else if (!button_delay_mode && rise[1])
            supply_ff <= !supply_ff;
    end

    // ************************************************************
    // disk timer
    // ************************************************************
    logic [3:0] hdd_idle_ff;
    logic       disk_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            hdd_idle_ff <= 4'h0;
        else if (disk_act || wake)
            hdd_idle_ff <= 4'h0;
        else if (tick.min_tick && hdd_idle_ff != `IPM_HDD_MAX_MIN)
            hdd_idle_ff <= hdd_idle_ff + 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            disk_ff <= 1'b1;
        else if (disk_act || nxt_state == IPM_ST_FULL && wake)
            disk_ff <= 1'b1;
        else if (hw_ctrl && hdd_min != 4'h0 && hdd_idle_ff >= hdd_min)
            disk_ff <= 1'b0;
        else if (hdd_off_on_suspend && nxt_state == IPM_ST_SUSPEND
                 && state_ff != IPM_ST_SUSPEND)
            disk_ff <= 1'b0;
    end

    // ************************************************************
    // throttle duty and outputs
    // ************************************************************
    logic [2:0] slot_ff;
    logic       cpu_en_ff;
    logic [3:0] stop_slots;

    // duty_sel 0..5 stops 1..6 slots of 8, i.e. 12.5 to 75 percent
    assign stop_slots = (duty_sel > `IPM_DUTY_DEFAULT) ? 4'(`IPM_DUTY_DEFAULT) + 4'h1
                                                       : 4'(duty_sel) + 4'h1;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            slot_ff <= 3'h0;
        else if (tick.duty_tick)
            slot_ff <= slot_ff + 3'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cpu_en_ff <= 1'b1;
        else unique case (state_ff)
            IPM_ST_THROTTLE: cpu_en_ff <= (4'(slot_ff) >= stop_slots);
            IPM_ST_FULL:     cpu_en_ff <= 1'b1;
            default:         cpu_en_ff <= (state_ff == IPM_ST_VIDOFF);
        endcase
    end

    logic vid_off;
    logic video_ff, sync_ff, blank_ff;
    assign vid_off = (state_ff == IPM_ST_VIDOFF) || (state_ff == IPM_ST_SUSPEND);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            video_ff <= 1'b1;
            sync_ff  <= 1'b1;
            blank_ff <= 1'b0;
        end
        else
        begin
            video_ff <= !vid_off;
            sync_ff  <= !(vid_off && video_method != IPM_VID_BLANK);
            blank_ff <= vid_off && video_method != IPM_VID_DPMS;
        end
    end

    assign pm_state    = state_ff;
    assign cpu_clk_en  = cpu_en_ff;
    assign video_on    = video_ff;
    assign sync_on     = sync_ff;
    assign blank_write = blank_ff;
    assign disk_on     = disk_ff;
    assign supply_on   = supply_ff;
endmodule

// file: bench/ipm_power_mgr_assertions.sv
// concurrent checks on the power manager top ports
`timescale 1ns/10ps
module ipm_power_mgr_checker
    import ipm_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       acpi_en,
    input wire logic       os_apm_ctrl,
    input wire logic       button_delay_mode,
    input wire logic       hdd_off_on_suspend,
    input wire ipm_vid_e   video_method,
    input wire logic       ring_wake_en,
    input wire logic       ring_ind,
    input wire ipm_state_e pm_state,
    input wire logic       cpu_clk_en,
    input wire logic       video_on,
    input wire logic       sync_on,
    input wire logic       disk_on,
    input wire logic       supply_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // cpu, video and sync outputs trail the state by one clock, hence the repetitions
    a_reset_vals: assert property (disable iff (1'b0)
        !rst_n |=> pm_state == IPM_ST_FULL && disk_on && !supply_on)
        else $error("outputs wrong after reset");
    a_acpi_full: assert property (acpi_en [*2] |-> pm_state == IPM_ST_FULL)
        else $error("saving state while os interface on");
    a_step_order: assert property ($changed(pm_state) && pm_state != IPM_ST_FULL
        && !os_apm_ctrl && !button_delay_mode |-> pm_state == $past(pm_state) + 1)
        else $error("saving states skipped");
    a_cpu_suspend: assert property ((pm_state == IPM_ST_SUSPEND) [*2] |-> !cpu_clk_en)
        else $error("cpu runs in suspend");
    a_video_off: assert property (
        (pm_state inside {IPM_ST_VIDOFF, IPM_ST_SUSPEND}) [*2] |-> !video_on)
        else $error("video on while off");
    a_full_run: assert property (
        (pm_state == IPM_ST_FULL) [*2] |-> cpu_clk_en && video_on)
        else $error("not full speed in full state");
    a_sync_stop: assert property (
        (pm_state == IPM_ST_VIDOFF && video_method == IPM_VID_SYNC_BLANK) [*3] |-> !sync_on)
        else $error("sync runs in sync blank mode");
    a_sync_keep: assert property (
        (pm_state == IPM_ST_VIDOFF && video_method == IPM_VID_BLANK) [*3] |-> sync_on)
        else $error("sync stopped in blank mode");
    a_disk_suspend: assert property (
        (pm_state == IPM_ST_SUSPEND && hdd_off_on_suspend) [*3] |-> !disk_on)
        else $error("disk on in suspend");
    a_ring_wake: assert property (pm_state == IPM_ST_SUSPEND && ring_wake_en
        && !acpi_en && $rose(ring_ind) |-> ##[3:10] pm_state == IPM_ST_FULL)
        else $error("ring did not wake");
    c_suspend: cover property (pm_state == IPM_ST_SUSPEND);
    c_throttle: cover property (pm_state == IPM_ST_THROTTLE && !cpu_clk_en);
    c_wake: cover property (pm_state == IPM_ST_SUSPEND ##1 pm_state == IPM_ST_FULL);
endmodule

bind ipm_power_mgr ipm_power_mgr_checker u_chk (.clk_sys, .rst_n, .acpi_en, .os_apm_ctrl,
    .button_delay_mode, .hdd_off_on_suspend, .video_method, .ring_wake_en, .ring_ind,
    .pm_state, .cpu_clk_en, .video_on, .sync_on, .disk_on, .supply_on);

// file: bench/ipm_cpu_model.sv
// cpu clock consumer: counts stopped cycles in a window
`timescale 1ns/10ps
module ipm_cpu_model
(
    input  wire logic       clk_sys,
    input  wire logic       cpu_clk_en,
    input  wire logic       meas,
    output logic      [7:0] gate_cnt
);
    // count holds at zero while meas is low; only a window of whole gate periods makes the phase of the gate pattern irrelevant
    always_ff @(posedge clk_sys)
    begin
        if (!meas)
            gate_cnt <= 8'h00;
        else if (!cpu_clk_en)
            gate_cnt <= gate_cnt + 8'h01;
    end
endmodule

// file: bench/ipm_power_mgr_test.sv
// self-checking bench for the inactivity power manager
`timescale 1ns/10ps
module ipm_power_mgr_test import ipm_pkg::*;;
    // short second keeps a minute at 480 clocks
    localparam int SC = 8;
    localparam int MN = 60 * SC;
    logic clk_sys, rst_n, acpi_en, os_apm_ctrl, hdd_off_on_suspend, video_mon_en;
    logic button_delay_mode, ring_wake_en, rtc_wake_en, alarm_resume_en, lan_wake_en;
    logic os_req_valid, video_act, ring_ind, rtc_alarm, alarm_match, lan_magic;
    logic power_button, mains_restore, last_state_on, meas;
    logic [5:0] throttle_min, vidoff_min, suspend_min;
    logic [3:0] hdd_min, ide_reload_en, ide_act;
    logic [2:0] duty_sel;
    logic [15:0] irq_reload_en, irq_act;
    logic nmi_reload_en, fdd_reload_en, ser_reload_en, par_reload_en;
    logic nmi_act, fdd_act, ser_act, par_act;
    logic [23:0] act_v, en_v;
    ipm_prof_e profile;
    ipm_vid_e video_method;
    ipm_pon_e power_on_after_loss;
    ipm_state_e os_req_state, pm_state, last_st;
    ipm_state_e exp_q[$];
    logic cpu_clk_en, video_on, sync_on, blank_write, disk_on, supply_on;
    logic [7:0] gate_cnt;
    int fail_count, comparisons, n;
    assign {par_reload_en, ser_reload_en, fdd_reload_en, ide_reload_en, nmi_reload_en,
        irq_reload_en} = en_v;
    assign {par_act, ser_act, fdd_act, ide_act, nmi_act, irq_act} = act_v;

    ipm_power_mgr #(.SEC_CYC(SC)) DUT (.*);
    ipm_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_clk_en(cpu_clk_en), .meas(meas),
        .gate_cnt(gate_cnt));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // note the expected state, then wait for it under a bound
    task automatic go(input ipm_state_e st, input int hi, output int k);
        exp_q.push_back(st);
        k = 0;
        while (pm_state !== st && k < hi)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (pm_state !== st)
        begin
            fail_count++;
            stop_test();
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************
    // state monitor
    // ****************
    always @(posedge clk_sys)
    begin
        #1;
        if (rst_n === 1'b1 && pm_state !== last_st)
        begin
            check(16'(pm_state), exp_q.size() > 0 ? 16'(exp_q.pop_front()) : 16'hffff);
            last_st = pm_state;
        end
    end

    initial
    begin
        void'($urandom(32'h21b9));
        {acpi_en, os_apm_ctrl, hdd_off_on_suspend, video_mon_en, button_delay_mode} = '0;
        {ring_wake_en, rtc_wake_en, alarm_resume_en, lan_wake_en, os_req_valid} = '0;
        {video_act, ring_ind, rtc_alarm, alarm_match, lan_magic, power_button} = '0;
        {mains_restore, last_state_on, meas, act_v, en_v} = '0;
        {throttle_min, vidoff_min, suspend_min, hdd_min} = '0;
        profile = IPM_PROF_MAX;
        video_method = IPM_VID_SYNC_BLANK;
        power_on_after_loss = IPM_PON_ON;
        os_req_state = IPM_ST_SUSPEND;
        duty_sel = 3'($urandom_range(7, 0));
        last_st = IPM_ST_FULL;
        fail_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        check(supply_on, 16'h0);
        mains_restore = 1'b1;
        cyc(1);
        mains_restore = 1'b0;
        cyc(3);
        check(supply_on, 16'h1);
        hdd_off_on_suspend = 1'b1;
        ring_wake_en = 1'b1;
        go(IPM_ST_THROTTLE, 2 * MN + 20, n);
        check(16'(n <= 2 * MN), 16'h1);
        cyc(4);
        meas = 1'b1;
        cyc(64);
        check(16'(gate_cnt), 16'(((duty_sel > 5 ? 5 : duty_sel) + 1) * 8));
        meas = 1'b0;
        go(IPM_ST_VIDOFF, MN + 20, n);
        cyc(4);
        check({sync_on, blank_write}, 16'h1);
        go(IPM_ST_SUSPEND, MN + 20, n);
        cyc(4);
        check({disk_on, cpu_clk_en}, 16'h0);
        ring_ind = 1'b1;
        go(IPM_ST_FULL, 20, n);
        ring_ind = 1'b0;
        profile = IPM_PROF_USER;
        {throttle_min, vidoff_min, suspend_min, hdd_min} = {6'h02, 6'h01, 6'h3c, 4'h1};
        video_method = IPM_VID_BLANK;
        {video_mon_en, video_act, hdd_off_on_suspend} = 3'b110;
        go(IPM_ST_THROTTLE, 3 * MN + 20, n);
        check(16'(n >= MN), 16'h1);
        cyc(2 * MN);
        check(16'(pm_state), 16'(IPM_ST_THROTTLE));
        check(disk_on, 16'h0);
        video_act = 1'b0;
        go(IPM_ST_VIDOFF, 2 * MN + 20, n);
        cyc(4);
        check({sync_on, blank_write}, 16'h3);
        rtc_wake_en = 1'b1;
        rtc_alarm = 1'b1;
        go(IPM_ST_FULL, 20, n);
        rtc_alarm = 1'b0;
        video_method = IPM_VID_DPMS;
        // every reload source in turn; irq 8 belongs to the clock alarm
        for (int i = 3; i < 24; i++)
        begin
            if (i != 8)
            begin
                go(IPM_ST_THROTTLE, 3 * MN + 20, n);
                check(16'(n >= MN), 16'h1);
                en_v = 24'h1 << i;
                act_v = en_v;
                go(IPM_ST_FULL, 20, n);
                act_v = '0;
            end
        end
        os_req_valid = 1'b1;
        cyc(1);
        os_req_valid = 1'b0;
        cyc(10);
        check(16'(pm_state), 16'(IPM_ST_FULL));
        os_apm_ctrl = 1'b1;
        // expectation is queued before the request can take effect
        os_req_valid = 1'b1;
        go(IPM_ST_SUSPEND, 20, n);
        os_req_valid = 1'b0;
        cyc(2);
        os_apm_ctrl = 1'b0;
        alarm_resume_en = 1'b1;
        alarm_match = 1'b1;
        go(IPM_ST_FULL, 20, n);
        alarm_match = 1'b0;
        profile = IPM_PROF_MIN;
        go(IPM_ST_THROTTLE, 61 * MN, n);
        check(16'(n >= 59 * MN), 16'h1);
        acpi_en = 1'b1;
        go(IPM_ST_FULL, 10, n);
        cyc(2 * MN);
        check(16'(pm_state), 16'(IPM_ST_FULL));
        acpi_en = 1'b0;
        power_button = 1'b1;
        cyc(10);
        power_button = 1'b0;
        cyc(10);
        check(supply_on, 16'h0);
        lan_wake_en = 1'b1;
        lan_magic = 1'b1;
        cyc(10);
        lan_magic = 1'b0;
        cyc(5);
        check(supply_on, 16'h1);
        // delayed button: suspend only after four second ticks of holding
        button_delay_mode = 1'b1;
        power_button = 1'b1;
        go(IPM_ST_SUSPEND, 8 * SC, n);
        check(16'(n >= 3 * SC), 16'h1);
        power_button = 1'b0;
        ring_ind = 1'b1;
        go(IPM_ST_FULL, 20, n);
        ring_ind = 1'b0;
        check(supply_on, 16'h1);
        stop_test();
    end
endmodule
